// >>> common/nirm_params.svh
// Contract
// - hardware reset clears both identifier registers to zero, which is not a legal identifier.
// - with an eeprom present, the upper identifier is filled from the eeprom port after pci reset.
// - without an eeprom, the upper identifier is taken from a config write at 0x70 or 0x80.
// - once either load method completes, the identifier registers become read only.
// - without an eeprom, the lower identifier is taken from a config write at 0x74 or 0x84.
// - a rom window quadlet read maps to host address base plus the low ten offset bits.
// - bits 9:0 of the rom mapping register always read as zero.
// - a posted write that fails records its error information in the two capture registers.
// - the low capture register takes the lower 32 bits of the failed destination offset.
// - the high capture register bits 31:16 take the failed requester bus and node number.
// - the high capture register bits 15:0 take the upper 16 bits of the failed offset.
// - the maker identification register reads a constant and ignores writes.
// - the link active flag is bit 17 of the host controller control register.
`ifndef NIRM_PARAMS_SVH
`define NIRM_PARAMS_SVH
`define NIRM_OFS_ID_UPPER 8'h24
`define NIRM_OFS_ID_LOWER 8'h28
`define NIRM_OFS_ROM_MAP 8'h34
`define NIRM_OFS_FAIL_LOW 8'h38
`define NIRM_OFS_FAIL_HIGH 8'h3c
`define NIRM_OFS_MAKER 8'h40
`define NIRM_CFG_ID_UPPER 8'h70
`define NIRM_CFG_ID_LOWER 8'h74
`define NIRM_CFG_ID_UPPER_ALT 8'h80
`define NIRM_CFG_ID_LOWER_ALT 8'h84
`define NIRM_ROM_WIN_LO 48'hffff_f000_0400
`define NIRM_ROM_WIN_HI 48'hffff_f000_07ff
`define NIRM_ROM_LSB 10
`define NIRM_LINK_ACTIVE_BIT 17
`define NIRM_ID_RESET 32'h0000_0000
`define NIRM_ROM_RESET 32'h0000_0000
// arbitrary neutral value
`define NIRM_MAKER_VALUE 32'h6c2e_91d4
`endif

// >>> common/nirm_pkg.sv
package nirm_pkg;
  typedef enum logic [1:0] {
    NIRM_OPEN,
    NIRM_LOCKED
  } nirm_load_t;

  typedef struct packed {
    logic [31:0] id_upper;
    logic [31:0] id_lower;
    logic upper_done;
    logic lower_done;
    nirm_load_t load_st;
    logic [21:0] rom_base;
    logic [31:0] fail_low;
    logic [31:0] fail_high;
    logic [31:0] rd_data;
    logic rd_valid;
    logic [31:0] rom_haddr;
    logic rom_hvalid;
    logic rom_miss;
    logic link_active_warn;
  } nirm_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
  } nirm_sync_t;
endpackage

// >>> design/nirm_sync.sv
`timescale 1ns/1ps
`include "nirm_params.svh"
module nirm_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic d,
  output logic q
);
  nirm_pkg::nirm_sync_t st_r;
  nirm_pkg::nirm_sync_t st_nxt;

  // first stage is read only by the second
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule

// >>> design/nirm_regs.sv
`timescale 1ns/1ps
`include "nirm_params.svh"
module nirm_regs (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pci_rst_n,
  input wire logic eeprom_present,
  input wire logic ee_upper_valid,
  input wire logic [31:0] ee_upper_data,
  input wire logic ee_lower_valid,
  input wire logic [31:0] ee_lower_data,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic rom_rd,
  input wire logic [47:0] rom_offset,
  input wire logic pw_fail,
  input wire logic [47:0] pw_fail_offset,
  input wire logic [15:0] pw_fail_source,
  input wire logic [31:0] host_ctrl,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  output logic [31:0] rom_host_addr,
  output logic rom_host_valid,
  output logic rom_read_miss,
  output logic [31:0] global_unique_identifier_hi,
  output logic [31:0] global_unique_identifier_lo,
  output logic identifier_locked,
  output logic id_invalid_while_active
);
  nirm_pkg::nirm_state_t st_r;
  nirm_pkg::nirm_state_t st_nxt;
  logic pci_rst_sync;
  logic pci_rst_prev_r;
  logic pci_rel;
  logic ee_present_s;
  logic link_active_flag;

  // the pci reset and eeprom strap come from outside this clock
  nirm_sync u_sync_rst (
    .clk(clk),
    .arst_n(arst_n),
    .d(pci_rst_n),
    .q(pci_rst_sync)
  );

  nirm_sync u_sync_ee (
    .clk(clk),
    .arst_n(arst_n),
    .d(eeprom_present),
    .q(ee_present_s)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pci_rst_prev_r <= 1'b0;
    end else begin
      pci_rst_prev_r <= pci_rst_sync;
    end
  end

  assign pci_rel = pci_rst_sync & ~pci_rst_prev_r;
  assign link_active_flag = host_ctrl[`NIRM_LINK_ACTIVE_BIT];

  function automatic logic is_upper_cfg(input logic [7:0] a);
    is_upper_cfg = (a == `NIRM_CFG_ID_UPPER) || (a == `NIRM_CFG_ID_UPPER_ALT);
  endfunction

  function automatic logic is_lower_cfg(input logic [7:0] a);
    is_lower_cfg = (a == `NIRM_CFG_ID_LOWER) || (a == `NIRM_CFG_ID_LOWER_ALT);
  endfunction

  function automatic logic in_rom_window(input logic [47:0] o);
    in_rom_window = (o >= `NIRM_ROM_WIN_LO) && (o <= `NIRM_ROM_WIN_HI);
  endfunction

  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_valid = 1'b0;
    st_nxt.rom_hvalid = 1'b0;
    st_nxt.rom_miss = 1'b0;
    case (st_r.load_st)
      nirm_pkg::NIRM_OPEN: begin
        if (ee_present_s) begin
          if (ee_upper_valid && !st_r.upper_done) begin
            st_nxt.id_upper = ee_upper_data;
            st_nxt.upper_done = 1'b1;
          end
          if (ee_lower_valid && !st_r.lower_done) begin
            st_nxt.id_lower = ee_lower_data;
            st_nxt.lower_done = 1'b1;
          end
        end else if (cfg_wr) begin
          if (is_upper_cfg(cfg_addr) && !st_r.upper_done) begin
            st_nxt.id_upper = cfg_wdata;
            st_nxt.upper_done = 1'b1;
          end
          if (is_lower_cfg(cfg_addr) && !st_r.lower_done) begin
            st_nxt.id_lower = cfg_wdata;
            st_nxt.lower_done = 1'b1;
          end
        end
        // a register lasts one load; both halves loaded closes the path
        if (st_nxt.upper_done && st_nxt.lower_done) begin
          st_nxt.load_st = nirm_pkg::NIRM_LOCKED;
        end
      end
      nirm_pkg::NIRM_LOCKED: begin
        st_nxt.load_st = nirm_pkg::NIRM_LOCKED;
      end
      default: begin
        st_nxt.load_st = nirm_pkg::NIRM_LOCKED;
      end
    endcase
    if (pci_rel) begin
      st_nxt.load_st = nirm_pkg::NIRM_OPEN;
      st_nxt.upper_done = 1'b0;
      st_nxt.lower_done = 1'b0;
    end
    if (reg_wr && reg_addr == `NIRM_OFS_ROM_MAP) begin
      st_nxt.rom_base = reg_wdata[31:`NIRM_ROM_LSB];
    end
    if (pw_fail) begin
      st_nxt.fail_low = pw_fail_offset[31:0];
      st_nxt.fail_high = {pw_fail_source, pw_fail_offset[47:32]};
    end
    if (rom_rd) begin
      if (in_rom_window(rom_offset)) begin
        st_nxt.rom_haddr = {st_r.rom_base, 10'h000} + {22'h000000, rom_offset[9:0]};
        st_nxt.rom_hvalid = 1'b1;
      end else begin
        st_nxt.rom_miss = 1'b1;
      end
    end
    if (reg_rd) begin
      st_nxt.rd_valid = 1'b1;
      case (reg_addr)
        `NIRM_OFS_ID_UPPER: st_nxt.rd_data = st_r.id_upper;
        `NIRM_OFS_ID_LOWER: st_nxt.rd_data = st_r.id_lower;
        `NIRM_OFS_ROM_MAP: st_nxt.rd_data = {st_r.rom_base, 10'h000};
        `NIRM_OFS_FAIL_LOW: st_nxt.rd_data = st_r.fail_low;
        `NIRM_OFS_FAIL_HIGH: st_nxt.rd_data = st_r.fail_high;
        `NIRM_OFS_MAKER: st_nxt.rd_data = `NIRM_MAKER_VALUE;
        default: st_nxt.rd_data = 32'h0000_0000;
      endcase
    end
    // flags a broken promise from outside rather than fixing it
    st_nxt.link_active_warn = link_active_flag &&
      (st_r.id_upper == `NIRM_ID_RESET || st_r.id_lower == `NIRM_ID_RESET);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.id_upper <= `NIRM_ID_RESET;
      st_r.id_lower <= `NIRM_ID_RESET;
      st_r.rom_base <= 22'(`NIRM_ROM_RESET >> `NIRM_ROM_LSB);
      st_r.load_st <= nirm_pkg::NIRM_LOCKED;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rd_data;
  assign reg_rvalid = st_r.rd_valid;
  assign rom_host_addr = st_r.rom_haddr;
  assign rom_host_valid = st_r.rom_hvalid;
  assign rom_read_miss = st_r.rom_miss;
  assign global_unique_identifier_hi = st_r.id_upper;
  assign global_unique_identifier_lo = st_r.id_lower;
  assign identifier_locked = (st_r.load_st == nirm_pkg::NIRM_LOCKED);
  assign id_invalid_while_active = st_r.link_active_warn;
endmodule

// >>> tb/nirm_regs_sva.sv
`timescale 1ns/1ps
`include "nirm_params.svh"
module nirm_regs_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic rom_rd,
  input wire logic [47:0] rom_offset,
  input wire logic [31:0] rom_host_addr,
  input wire logic rom_host_valid,
  input wire logic rom_read_miss,
  input wire logic pw_fail,
  input wire logic [47:0] pw_fail_offset,
  input wire logic [15:0] pw_fail_source,
  input wire logic [31:0] global_unique_identifier_hi,
  input wire logic [31:0] global_unique_identifier_lo,
  input wire logic identifier_locked
);
  logic [9:0] rom_low;
  logic [31:0] fail_hi;
  logic [31:0] fail_lo;
  logic in_win;
  assign rom_low = rom_offset[9:0];
  assign fail_hi = {pw_fail_source, pw_fail_offset[47:32]};
  assign fail_lo = pw_fail_offset[31:0];
  assign in_win = rom_offset >= `NIRM_ROM_WIN_LO && rom_offset <= `NIRM_ROM_WIN_HI;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_reset_clear: assert property ($rose(arst_n) |->
    {global_unique_identifier_hi, global_unique_identifier_lo} == 64'h0) else $error("id not 0");
  chk_id_frozen: assert property (identifier_locked && $past(identifier_locked) |->
    $stable({global_unique_identifier_hi, global_unique_identifier_lo})) else $error("id moved");
  chk_rom_zero_bits: assert property (reg_rd && reg_addr == `NIRM_OFS_ROM_MAP |=>
    reg_rvalid && reg_rdata[9:0] == 10'h0) else $error("rom map low bits");
  chk_maker_const: assert property (reg_rd && reg_addr == `NIRM_OFS_MAKER |=>
    reg_rvalid && reg_rdata == `NIRM_MAKER_VALUE) else $error("maker word");
  chk_rom_hit: assert property (rom_rd && in_win |=>
    rom_host_valid && !rom_read_miss && rom_host_addr[9:0] == $past(rom_low))
    else $error("rom hit");
  chk_rom_miss: assert property (rom_rd && !in_win |=> rom_read_miss && !rom_host_valid)
    else $error("rom miss");
  chk_fail_high: assert property (pw_fail ##1 (reg_rd && !pw_fail &&
    reg_addr == `NIRM_OFS_FAIL_HIGH) |=> reg_rdata == $past(fail_hi, 2)) else $error("fail hi");
  chk_fail_low: assert property (pw_fail ##1 (reg_rd && !pw_fail &&
    reg_addr == `NIRM_OFS_FAIL_LOW) |=> reg_rdata == $past(fail_lo, 2)) else $error("fail lo");
endmodule
bind nirm_regs nirm_regs_chk u_chk (.*);

// >>> tb/nirm_ee_model.sv
`timescale 1ns/1ps
module nirm_ee_model (
  input wire logic clk,
  input wire logic start,
  input wire logic [31:0] hi,
  input wire logic [31:0] lo,
  output logic up_v,
  output logic [31:0] up_d,
  output logic lo_v,
  output logic [31:0] lo_d
);
  initial begin
    {up_v, lo_v, up_d, lo_d} = '0;
  end
  // released data shows the inverse so a late sample cannot pass by luck
  always @(posedge start) begin
    repeat (4) @(posedge clk);
    #1 {up_v, up_d} = {1'b1, hi};
    @(posedge clk);
    #1 {up_v, up_d, lo_v, lo_d} = {1'b0, ~hi, 1'b1, lo};
    @(posedge clk);
    #1 {lo_v, lo_d} = {1'b0, ~lo};
  end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "nirm_params.svh"
module testbench;
  logic clk, arst_n, pci_rst_n, eeprom_present, ee_upper_valid, ee_lower_valid, ee_go, cfg_wr;
  logic reg_wr, reg_rd, rom_rd, pw_fail, reg_rvalid, rom_host_valid, rom_read_miss;
  logic identifier_locked, id_invalid_while_active;
  logic [7:0] cfg_addr, reg_addr;
  logic [15:0] pw_fail_source;
  logic [31:0] ee_upper_data, ee_lower_data, cfg_wdata, reg_wdata, host_ctrl, reg_rdata, w;
  logic [31:0] rom_host_addr, global_unique_identifier_hi, global_unique_identifier_lo, e_hi, e_lo;
  logic [47:0] rom_offset, pw_fail_offset;
  logic [7:0] offs [7] = '{8'h24, 8'h28, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h60};
  logic [47:0] corner [4] = '{`NIRM_ROM_WIN_LO - 48'h1, `NIRM_ROM_WIN_LO, `NIRM_ROM_WIN_HI,
    `NIRM_ROM_WIN_HI + 48'h1};
  int miscompares, n_checks;
  nirm_regs dut (.*);
  nirm_ee_model u_ee (.clk(clk), .start(ee_go), .hi(e_hi), .lo(e_lo), .up_v(ee_upper_valid),
    .up_d(ee_upper_data), .lo_v(ee_lower_valid), .lo_d(ee_lower_data));
  function automatic logic in_win(input logic [47:0] o);
    return o >= `NIRM_ROM_WIN_LO && o <= `NIRM_ROM_WIN_HI;
  endfunction
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    {reg_addr, reg_rd} = {a, 1'b1};
    tick();
    reg_rd = 0;
    chk("reg_rvalid", 1, reg_rvalid);
    chk($sformatf("reg_rdata at %h", a), e, reg_rdata);
    tick();
  endtask
  task automatic wr(input logic cfg, input logic [7:0] a, input logic [31:0] d);
    {cfg_addr, reg_addr, cfg_wdata, reg_wdata, cfg_wr, reg_wr} = {a, a, d, d, cfg, !cfg};
    tick();
    {cfg_wr, reg_wr} = 2'b00;
    tick();
  endtask
  task automatic pci_pulse();
    pci_rst_n = 0;
    repeat (3) tick();
    pci_rst_n = 1;
    repeat (4) tick();
  endtask
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
  initial begin
    {arst_n, pci_rst_n, eeprom_present, ee_go, cfg_wr, reg_wr, reg_rd, rom_rd, pw_fail} = '0;
    {cfg_addr, reg_addr, cfg_wdata, reg_wdata, host_ctrl, rom_offset} = '0;
    {pw_fail_offset, pw_fail_source, e_hi, e_lo} = '0;
    w = $urandom(32'hcc751e89);
    repeat (8) @(posedge clk);
    #1 arst_n = 1;
    foreach (offs[i]) rd(offs[i], offs[i] == 8'h40 ? `NIRM_MAKER_VALUE : 32'h0);
    wr(1, 8'h70, 32'h5a5a_0001);
    wr(0, 8'h40, $urandom);
    rd(8'h40, `NIRM_MAKER_VALUE);
    rd(8'h24, 32'h0);
    host_ctrl = $urandom | 32'h0002_0000;
    repeat (2) tick();
    chk("id_invalid_while_active", 1, id_invalid_while_active);
    for (int i = 0; i < 2; i++) begin
      pci_pulse();
      e_hi = $urandom | 32'h1;
      e_lo = $urandom | 32'h1;
      wr(1, i ? 8'h80 : 8'h70, e_hi);
      wr(1, i ? 8'h74 : 8'h84, e_lo);
      chk("identifier_locked", 1, identifier_locked);
      wr(1, 8'h70, ~e_hi);
      rd(8'h24, e_hi);
      rd(8'h28, e_lo);
    end
    chk("id_invalid_while_active", 0, id_invalid_while_active);
    {eeprom_present, e_hi, e_lo} = {1'b1, $urandom | 32'h1, $urandom | 32'h1};
    pci_pulse();
    wr(1, 8'h70, 32'h0);
    ee_go = 1;
    for (int k = 0; k < 40 && identifier_locked !== 1'b1; k++) tick();
    chk("identifier_locked", 1, identifier_locked);
    rd(8'h24, e_hi);
    rd(8'h28, e_lo);
    w = $urandom;
    wr(0, 8'h34, w);
    rd(8'h34, {w[31:10], 10'h0});
    for (int k = 0; k < 6; k++) begin
      rom_offset = k < 4 ? corner[k] : `NIRM_ROM_WIN_LO + 48'($urandom_range(1023));
      rom_rd = 1;
      tick();
      rom_rd = 0;
      chk("rom_read_miss", !in_win(rom_offset), rom_read_miss);
      if (in_win(rom_offset)) chk("rom_host_addr", {w[31:10], rom_offset[9:0]}, rom_host_addr);
      tick();
    end
    for (int k = 0; k < 2; k++) begin
      {pw_fail_offset, pw_fail_source, pw_fail} = {48'({$urandom, $urandom}), 16'($urandom), 1'b1};
      tick();
      pw_fail = 0;
      if (k) rd(8'h38, pw_fail_offset[31:0]);
      rd(8'h3c, {pw_fail_source, pw_fail_offset[47:32]});
      if (!k) rd(8'h38, pw_fail_offset[31:0]);
    end
    give_verdict();
  end
endmodule
